// File: cti_channel_tx_irq.sv
// Purpose: transmit driver control and block-level interrupt enable registers
// Assumes: serial port pins synchronous to clk, sclk slower than clk/2
// Notes:   frame = r/w bit, 7 address bits, 8 data bits, all msb first
`timescale 1ns/10ps
module cti_channel_tx_irq (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // serial register port
  input  wire cti_pkg::cti_ser_t   ser,
  output logic                     serDataOut,
  output logic                     serDataOe,
  // hardware driver enable pins
  input  wire logic                driverEnablePinCh1,
  input  wire logic                driverEnablePinCh0,
  // line pulses from the encoder
  input  wire cti_pkg::cti_pulse_t txPulseCh1,
  input  wire cti_pkg::cti_pulse_t txPulseCh0,
  // line outputs
  output logic                     lineOutPosCh1,
  output logic                     lineOutNegCh1,
  output logic                     lineOutOeCh1,
  output logic                     lineOutPosCh0,
  output logic                     lineOutNegCh0,
  output logic                     lineOutOeCh0,
  // channel interrupts, source-level already applied
  input  wire logic [2:0]          chanSrcIrq,
  output logic [2:0]               chanIrq
);
  import cti_pkg::*;

  // ***************************************************************
  // serial port state
  // ***************************************************************
  cti_state_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [6:0] addr_ff, nxt_addr;
  logic       rw_ff, nxt_rw;
  logic       sdo_ff, nxt_sdo;
  logic       oe_ff, nxt_oe;
  logic       sclkPrev_ff;
  logic [7:0] irqEn_ff, nxt_irqEn;
  logic [7:0] txCtrl_ff, nxt_txCtrl;
  logic       sclkRise;
  logic [6:0] hdrAddr;
  logic [7:0] wrData;

  assign sclkRise = ser.sclk & ~sclkPrev_ff;
  assign hdrAddr  = {shift_ff[5:0], ser.sdi};
  assign wrData   = {shift_ff[6:0], ser.sdi};

  function automatic logic [7:0] readReg(input logic [6:0] a,
                                         input logic [7:0] ie,
                                         input logic [7:0] tc);
    logic [7:0] r;
    r = READ_UNMAPPED;
    if (a == ADDR_IRQ_EN) begin
      r = ie & MASK_IRQ_EN;
    end else if (a == ADDR_TX_CTRL) begin
      r = tc & MASK_TX_CTRL;
    end
    return r;
  endfunction : readReg

  always_comb begin
    logic [7:0] rd;
    rd         = READ_UNMAPPED;
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_shift  = shift_ff;
    nxt_addr   = addr_ff;
    nxt_rw     = rw_ff;
    nxt_sdo    = sdo_ff;
    nxt_oe     = oe_ff;
    nxt_irqEn  = irqEn_ff;
    nxt_txCtrl = txCtrl_ff;
    if (ser.csN) begin
      // chip select high aborts any partial frame, nothing is written
      nxt_state = CTI_IDLE;
      nxt_cnt   = CNT_ZERO;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        CTI_IDLE: begin
          nxt_state = CTI_HDR;
          nxt_cnt   = CNT_ZERO;
        end
        CTI_HDR: begin
          if (sclkRise) begin
            nxt_shift = wrData;
            nxt_cnt   = cnt_ff + CNT_ONE;
            if (cnt_ff == HDR_LAST) begin
              nxt_rw    = shift_ff[6];
              nxt_addr  = hdrAddr;
              nxt_state = CTI_DATA;
              if (shift_ff[6]) begin
                rd        = readReg(hdrAddr, irqEn_ff, txCtrl_ff);
                nxt_sdo   = rd[7];
                nxt_shift = {rd[6:0], 1'b0};
                nxt_oe    = 1'b1;
              end
            end
          end
        end
        CTI_DATA: begin
          if (sclkRise) begin
            nxt_cnt = cnt_ff + CNT_ONE;
            if (rw_ff) begin
              nxt_sdo   = shift_ff[7];
              nxt_shift = {shift_ff[6:0], 1'b0};
            end else begin
              nxt_shift = wrData;
            end
            if (cnt_ff == FRAME_LAST) begin
              nxt_state = CTI_DONE;
              nxt_oe    = 1'b0;
              if (!rw_ff && addr_ff == ADDR_IRQ_EN) begin
                nxt_irqEn = wrData & MASK_IRQ_EN;
              end else if (!rw_ff && addr_ff == ADDR_TX_CTRL) begin
                nxt_txCtrl = wrData & MASK_TX_CTRL;
              end
            end
          end
        end
        CTI_DONE: begin
          nxt_state = CTI_DONE;
        end
        default: begin
          nxt_state = CTI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff    <= CTI_IDLE;
      cnt_ff      <= CNT_ZERO;
      shift_ff    <= 8'h00;
      addr_ff     <= 7'h00;
      rw_ff       <= 1'b0;
      sdo_ff      <= 1'b0;
      oe_ff       <= 1'b0;
      sclkPrev_ff <= 1'b0;
      irqEn_ff    <= RST_IRQ_EN;
      txCtrl_ff   <= RST_TX_CTRL;
    end else begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      shift_ff    <= nxt_shift;
      addr_ff     <= nxt_addr;
      rw_ff       <= nxt_rw;
      sdo_ff      <= nxt_sdo;
      oe_ff       <= nxt_oe;
      sclkPrev_ff <= ser.sclk;
      irqEn_ff    <= nxt_irqEn;
      txCtrl_ff   <= nxt_txCtrl;
    end
  end

  assign serDataOut = sdo_ff;
  assign serDataOe  = oe_ff;

  // ***************************************************************
  // interrupt gating
  // ***************************************************************
  // enable clear blocks the channel, set passes source-enabled requests
  assign chanIrq = chanSrcIrq & irqEn_ff[2:0];

  // ***************************************************************
  // line drivers
  // ***************************************************************
  cti_line_driver u_drv_ch1 (
    .clk       (clk),
    .reset     (reset),
    .softOn    (txCtrl_ff[TX_BIT_CH1]),
    .pinEnable (driverEnablePinCh1),
    .pulseIn   (txPulseCh1),
    .outPos    (lineOutPosCh1),
    .outNeg    (lineOutNegCh1),
    .outOe     (lineOutOeCh1)
  );

  cti_line_driver u_drv_ch0 (
    .clk       (clk),
    .reset     (reset),
    .softOn    (txCtrl_ff[TX_BIT_CH0]),
    .pinEnable (driverEnablePinCh0),
    .pulseIn   (txPulseCh0),
    .outPos    (lineOutPosCh0),
    .outNeg    (lineOutNegCh0),
    .outOe     (lineOutOeCh0)
  );

  // ***************************************************************
  // checks
  // ***************************************************************
  a_ch1_off_float: assert property (@(posedge clk) disable iff (reset)
    !txCtrl_ff[TX_BIT_CH1] |=> !lineOutOeCh1 && !lineOutPosCh1 && !lineOutNegCh1)
    else $error("ch1 driver active with bit clear");
  a_ch1_on_pulse: assert property (@(posedge clk) disable iff (reset)
    txCtrl_ff[TX_BIT_CH1] && driverEnablePinCh1 |=>
      lineOutOeCh1 && lineOutPosCh1 == $past(txPulseCh1.pos))
    else $error("ch1 driver not passing pulses");
  a_ch1_pin_rules: assert property (@(posedge clk) disable iff (reset)
    !driverEnablePinCh1 |=> !lineOutOeCh1)
    else $error("ch1 driver on with pin low");
  a_ch0_driver_gate: assert property (@(posedge clk) disable iff (reset)
    ##1 lineOutOeCh0 == $past(txCtrl_ff[TX_BIT_CH0] & driverEnablePinCh0))
    else $error("ch0 driver state wrong");
  a_ch2_irq_pass: assert property (@(posedge clk) disable iff (reset)
    irqEn_ff[2] && chanSrcIrq[2] |-> chanIrq[2])
    else $error("ch2 interrupt lost");
  a_ch2_irq_block: assert property (@(posedge clk) disable iff (reset)
    !irqEn_ff[2] |-> !chanIrq[2])
    else $error("ch2 interrupt leaked");
  a_ch10_irq_gate: assert property (@(posedge clk) disable iff (reset)
    chanIrq[1:0] == (chanSrcIrq[1:0] & irqEn_ff[1:0]))
    else $error("ch1/ch0 interrupt gating wrong");
  a_irqen_upper_zero: assert property (@(posedge clk)
    $past(reset) |-> irqEn_ff == RST_IRQ_EN)
    else $error("irq enable reset value wrong");
  a_irqen_write_mask: assert property (@(posedge clk) disable iff (reset)
    state_ff == CTI_DATA && nxt_state == CTI_DONE && !rw_ff && addr_ff == ADDR_IRQ_EN
      |=> irqEn_ff == ($past(wrData) & MASK_IRQ_EN) && irqEn_ff[7:3] == 5'h00)
    else $error("irq enable write wrong");

  c_read_frame: cover property (@(posedge clk) disable iff (reset)
    rw_ff && state_ff == CTI_DATA ##1 state_ff == CTI_DONE);
  c_irqen_write: cover property (@(posedge clk) disable iff (reset)
    $rose(irqEn_ff[2]));
  c_ch2_irq: cover property (@(posedge clk) disable iff (reset) chanIrq[2]);
  c_ch1_on: cover property (@(posedge clk) disable iff (reset) $rose(lineOutOeCh1));

endmodule : cti_channel_tx_irq

// File: cti_pkg.sv
// Purpose: constants and types shared by the channel transmit and irq enable block
// Assumes: one clock, synchronous active-high reset
// Notes:   serial register port, 8-bit registers, 7-bit addresses
// Behaviour
// - clearing channel 1 driver bit powers driver off, both line outputs float
// - setting channel 1 driver bit turns driver on, line pulses reach outputs
// - software bit acts only while channel 1 enable pin is high, else pin governs
// - bit 0 controls channel 0 driver likewise, gated by channel 0 pin
// - channel 2 enable set: channel 2 source raises interrupt only if source-enabled
// - channel 2 enable clear: every channel 2 interrupt is suppressed
// - enable bits 1 and 0 gate channel 1 and channel 0 interrupts likewise
// - interrupt enable register at 0x20, resets zero, bits 7..3 read zero
package cti_pkg;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [6:0] ADDR_IRQ_EN  = 7'h20;
  localparam logic [6:0] ADDR_TX_CTRL = 7'h05;
  localparam logic [7:0] RST_IRQ_EN   = 8'h00;
  localparam logic [7:0] RST_TX_CTRL  = 8'h00;
  localparam logic [7:0] MASK_IRQ_EN  = 8'h07;
  localparam logic [7:0] MASK_TX_CTRL = 8'h03;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam int         TX_BIT_CH1   = 1;
  localparam int         TX_BIT_CH0   = 0;

  // ***************************************************************
  // serial frame
  // ***************************************************************
  localparam logic [4:0] HDR_LAST   = 5'h07;
  localparam logic [4:0] FRAME_LAST = 5'h0f;
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [4:0] CNT_ONE    = 5'h01;

  typedef enum logic [1:0] {
    CTI_IDLE = 2'b00,
    CTI_HDR  = 2'b01,
    CTI_DATA = 2'b10,
    CTI_DONE = 2'b11
  } cti_state_t;

  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } cti_ser_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } cti_pulse_t;

endpackage : cti_pkg

// File: cti_line_driver.sv
// Purpose: one channel's line driver gate
// Assumes: pulses arrive synchronous to clk
// Notes:   outputs and enable come from flip-flops, one cycle behind inputs
`timescale 1ns/10ps
module cti_line_driver (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // control
  input  wire logic              softOn,
  input  wire logic              pinEnable,
  // line
  input  wire cti_pkg::cti_pulse_t pulseIn,
  output logic                   outPos,
  output logic                   outNeg,
  output logic                   outOe
);
  import cti_pkg::*;

  logic driveOn;
  logic outPos_ff, outNeg_ff, outOe_ff;
  logic nxt_outPos, nxt_outNeg, nxt_outOe;

  // pin low forces off; pin high hands control to software
  assign driveOn = softOn & pinEnable;

  always_comb begin
    nxt_outOe  = driveOn;
    nxt_outPos = driveOn & pulseIn.pos;
    nxt_outNeg = driveOn & pulseIn.neg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      outPos_ff <= 1'b0;
      outNeg_ff <= 1'b0;
      outOe_ff  <= 1'b0;
    end else begin
      outPos_ff <= nxt_outPos;
      outNeg_ff <= nxt_outNeg;
      outOe_ff  <= nxt_outOe;
    end
  end

  assign outPos = outPos_ff;
  assign outNeg = outNeg_ff;
  assign outOe  = outOe_ff;

endmodule : cti_line_driver

// File: tb_cti_top.sv
// Purpose: self-checking bench for the transmit control and interrupt enable block
// Assumes: serial frames of 16 bits, sclk phases of 2 clk, csN high between frames
// Notes:   read data is decoded off the port by a monitor and checked against a queue
`timescale 1ns/10ps
module tb_top;
  import cti_pkg::*;
  logic       clk;
  logic       reset;
  cti_ser_t   ser;
  logic       serDataOut;
  logic       serDataOe;
  logic       pinCh1;
  logic       pinCh0;
  cti_pulse_t pulseCh1;
  cti_pulse_t pulseCh0;
  logic [5:0] lineOut;
  logic [2:0] srcIrq;
  logic [2:0] chanIrq;
  logic [7:0] expQ[$];
  logic [7:0] shData;
  logic [7:0] val;
  logic [5:0] expLine;
  logic       sclkPrev;
  logic       isRead;
  int         miscompares;
  int         num_checks;
  int         rises;
  int         seed;

  cti_channel_tx_irq i_dut (
    .clk(clk), .reset(reset), .ser(ser), .serDataOut(serDataOut), .serDataOe(serDataOe),
    .driverEnablePinCh1(pinCh1), .driverEnablePinCh0(pinCh0),
    .txPulseCh1(pulseCh1), .txPulseCh0(pulseCh0),
    .lineOutPosCh1(lineOut[4]), .lineOutNegCh1(lineOut[3]), .lineOutOeCh1(lineOut[5]),
    .lineOutPosCh0(lineOut[1]), .lineOutNegCh0(lineOut[0]), .lineOutOeCh0(lineOut[2]),
    .chanSrcIrq(srcIrq), .chanIrq(chanIrq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // a short nBits leaves the frame unfinished, which the port must discard
  task automatic xfer(input logic rw, input logic [6:0] addr, input logic [7:0] data,
                      input int nBits = 16);
    logic [15:0] frame;
    frame = {rw, addr, data};
    ser.csN <= 1'b0;
    tick(2);
    for (int i = 15; i > 15 - nBits; i--) begin
      ser.sdi  <= frame[i];
      ser.sclk <= 1'b0;
      tick(2);
      ser.sclk <= 1'b1;
      tick(2);
    end
    ser.sclk <= 1'b0;
    tick(2);
    ser.csN <= 1'b1;
    tick(3);
  endtask : xfer

  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    expQ.push_back(exp);
    xfer(1'b1, addr, 8'h00);
  endtask : rd

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // ***************************************************************
  // read data monitor
  // ***************************************************************
  // sees the same pre-edge samples as the port, so rise counts agree
  always @(posedge clk) begin
    if (ser.csN || reset) begin
      rises = 0;
    end else if (!sclkPrev && ser.sclk) begin
      rises++;
      if (rises == 1) isRead = ser.sdi;
      // the port may drive only in the data phase of a read frame
      if (rises == 9) chk("serDataOe", {7'h00, isRead}, {7'h00, serDataOe});
      if (rises >= 9) shData = {shData[6:0], serDataOut};
      if (rises == 16 && isRead) begin
        if (expQ.size() == 0) chk("read count", 8'h00, 8'h01);
        else chk("read data", expQ.pop_front(), shData);
      end
    end
    sclkPrev = ser.sclk;
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    seed = 32'haeae;
    reset = 1'b1;
    ser = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};
    pinCh1 = 1'b0;
    pinCh0 = 1'b0;
    pulseCh1 = '0;
    pulseCh0 = '0;
    srcIrq = 3'h0;
    sclkPrev = 1'b0;
    tick(2);
    reset <= 1'b0;
    tick(1);
    rd(ADDR_IRQ_EN, 8'h00);
    rd(ADDR_TX_CTRL, 8'h00);
    xfer(1'b0, ADDR_IRQ_EN, 8'hff);
    rd(ADDR_IRQ_EN, 8'h07);
    xfer(1'b0, ADDR_IRQ_EN, 8'h02, 10);
    rd(ADDR_IRQ_EN, 8'h07);
    xfer(1'b0, 7'h21, 8'h00);
    rd(7'h21, 8'h00);
    rd(ADDR_IRQ_EN, 8'h07);
    for (int ie = 0; ie < 8; ie++) begin
      val = $random(seed);
      xfer(1'b0, ADDR_IRQ_EN, {val[7:3], 3'(ie)});
      rd(ADDR_IRQ_EN, {5'h00, 3'(ie)});
      for (int s = 0; s < 8; s++) begin
        srcIrq <= 3'(s);
        tick(1);
        chk("chanIrq", {5'h00, 3'(s & ie)}, {5'h00, chanIrq});
      end
    end
    for (int tc = 0; tc < 4; tc++) begin
      val = $random(seed);
      xfer(1'b0, ADDR_TX_CTRL, {val[7:2], 2'(tc)});
      rd(ADDR_TX_CTRL, {6'h00, 2'(tc)});
      for (int p = 0; p < 8; p++) begin
        val = $random(seed);
        pinCh1 <= p[1];
        pinCh0 <= p[0];
        pulseCh1 <= val[3:2];
        pulseCh0 <= val[1:0];
        expLine[5] = tc[1] & p[1];
        expLine[2] = tc[0] & p[0];
        expLine[4:3] = val[3:2] & {2{expLine[5]}};
        expLine[1:0] = val[1:0] & {2{expLine[2]}};
        tick(2);
        chk("line ch1", {5'h00, expLine[5:3]}, {5'h00, lineOut[5:3]});
        chk("line ch0", {5'h00, expLine[2:0]}, {5'h00, lineOut[2:0]});
      end
    end
    chk("queue left", 8'h00, 8'(expQ.size()));
    end_sim();
  end

  // about 2500 cycles expected, eight times that as margin
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule : tb_top
